// [verilog/pack_fault_regs.vh]
// register offsets, field positions and scale constants for the pack fault status logic
// Summary of operation
// RULE_01 - cell above lockout level sets lockout flag, charge and balance off, shutdown high
// RULE_02 - lockout flag clears only once all cells fall below recovery level
// RULE_03 - all-ones lockout level disables lockout; scan override plus charge enable bypasses
// RULE_04 - controller owning the scan must do all cell scans, compares, timing, balancing
// RULE_05 - cell above high level for delay sets timed flag; charge off unless external control
// RULE_06 - all cells below recovery for delay clear timed flag; charge back unless external
// RULE_07 - maximum high-level code disables timed high-cell detection
// RULE_08 - cell above charge-complete level sets flag and pulls pin low; charge stays on
// RULE_09 - charge-complete flag clears when all cells below level minus 117 mV hysteresis
// RULE_10 - balance-at-charge-complete option balances while flag set, any current direction
// RULE_11 - open sense lead sets flag; balance and power off unless external control
// RULE_12 - open-lead flag clears on clean later scan; option forces shutdown; disable bit
// RULE_13 - cell spread above limit sets imbalance flag; balance and power off unless external
// RULE_14 - imbalance flag clears on later in-limit measurement set; option forces shutdown
// RULE_15 - all-ones spread limit disables imbalance and therefore open-lead detection
// RULE_16 - short beyond its delay sets short and load flags; balance and power always off
// RULE_17 - discharge overcurrent beyond delay sets flags; power off unless external control
// RULE_18 - two clear load scans clear short/overcurrent flags; switches back unless external
// RULE_19 - under external control the controller pulses load watch and clears load error
// RULE_20 - charge overcurrent beyond delay sets flags; power off unless external control
// RULE_21 - two charger-free scans clear charge overcurrent, else controller clears it
// RULE_22 - die overheat sets flag, stops balancing, power off until below recovery limit
`ifndef PACK_FAULT_REGS_VH
`define PACK_FAULT_REGS_VH
`define PRIMARY_FAULT_STATUS_ADDR 8'h80
`define SECONDARY_FAULT_STATUS_ADDR 8'h81
`define LEVEL_DISABLE_CODE 12'hFFF
`define EOC_HYST_MV 117
`define CELL_FULL_SCALE_MV 4800
`define EOC_HYST_CODE 12'h064
`define LOAD_CLEAR_SCANS 2'h2
`define BIT_HIGH_CELL_FLAG 0
`define BIT_LOCKOUT_FLAG 1
`define BIT_DIE_OVERHEAT 0
`define BIT_CHARGE_OC 1
`define BIT_DISCHARGE_OC 2
`define BIT_SHORT 3
`define BIT_IMBALANCE 4
`define BIT_BROKEN_LEAD 5
`define BIT_CHARGE_COMPLETE 7
`endif

// [verilog/fault_delay_timer.v]
// qualification timer: a condition must hold for a unit-times-count delay
module fault_delay_timer #(
   parameter CW = 16
) (
   input wire CORE_CLK_I,
   input wire SYS_RST_I,
   input wire cond_i,
   input wire tick_i,
   input wire [CW-1:0] limit_i,
   output wire done_o
);
   reg [CW-1:0] cnt_ff;
   reg [CW-1:0] nxt_cnt;

   // count ticks while the condition holds, restart the moment it drops
   always @* begin
      nxt_cnt = cnt_ff;
      if (!cond_i)
         nxt_cnt = {CW{1'b0}};
      else if (tick_i && cnt_ff <= limit_i)
         nxt_cnt = cnt_ff + {{(CW-1){1'b0}}, 1'b1};
   end

   always @(posedge CORE_CLK_I) begin
      if (SYS_RST_I)
         cnt_ff <= {CW{1'b0}};
      else
         cnt_ff <= nxt_cnt;
   end

   // strictly longer than the limit
   assign done_o = cond_i && (cnt_ff > limit_i);
endmodule // fault_delay_timer

// [verilog/pack_fault_status.v]
// fault detection, latching and recovery behind the two fault status registers
`include "pack_fault_regs.vh"
module pack_fault_status #(
   parameter NCELL = 8,
   parameter TW = 16
) (
   input wire CORE_CLK_I,
   input wire SYS_RST_I,
   // scan results, one strobe per completed measurement set
   input wire SCAN_DONE_I,
   input wire [11:0] CELL_MAX_I,
   input wire [11:0] CELL_MIN_I,
   input wire DELAY_TICK_I,
   // thresholds and options
   input wire [11:0] HIGH_CELL_LOCKOUT_I,
   input wire [11:0] HIGH_CELL_LEVEL_I,
   input wire [11:0] HIGH_CELL_RECOVERY_LEVEL_I,
   input wire [TW-1:0] HIGH_CELL_DELAY_I,
   input wire [11:0] CHARGE_COMPLETE_LEVEL_I,
   input wire [11:0] MAX_BALANCE_DIFFERENTIAL_I,
   input wire BALANCE_AT_CHARGE_COMPLETE_I,
   input wire BROKEN_LEAD_FORCES_SHUTDOWN_I,
   input wire BROKEN_LEAD_TEST_DISABLE_I,
   input wire IMBALANCE_FORCES_SHUTDOWN_I,
   // open-lead scan result
   input wire BROKEN_LEAD_SCAN_DONE_I,
   input wire BROKEN_LEAD_FOUND_I,
   // analog comparators and their qualified delays
   input wire SHORT_OVER_I,
   input wire [TW-1:0] DISCHARGE_SHORT_DELAY_I,
   input wire DOC_OVER_I,
   input wire [TW-1:0] DOC_DELAY_I,
   input wire COC_OVER_I,
   input wire [TW-1:0] COC_DELAY_I,
   input wire DIE_ABOVE_LIMIT_I,
   input wire DIE_BELOW_RECOVERY_I,
   // load and charger watch scans
   input wire LOAD_WATCH_SCAN_I,
   input wire LOAD_WATCH_PIN_LOAD_I,
   input wire CHARGER_WATCH_SCAN_I,
   input wire CHARGER_WATCH_PIN_CHARGER_I,
   // controller control bits
   input wire EXTERNAL_POWER_SWITCH_CONTROL_I,
   input wire EXTERNAL_SCAN_OVERRIDE_I,
   input wire EXTERNAL_LOAD_WATCH_CONTROL_I,
   input wire EXTERNAL_CHARGER_WATCH_CONTROL_I,
   input wire LOAD_ERROR_CLEAR_I,
   input wire CHARGER_ERROR_CLEAR_I,
   input wire HOST_CHARGE_SWITCH_I,
   input wire HOST_DISCHARGE_SWITCH_I,
   input wire HOST_PRECHARGE_SWITCH_I,
   input wire PRECHARGE_SELECT_I,
   input wire [NCELL-1:0] BALANCE_REQUEST_I,
   input wire CHARGING_I,
   // register read port
   input wire [7:0] REG_ADDR_I,
   output reg [7:0] REG_RDATA_O,
   // actions
   output wire CHARGE_SWITCH_DRIVE_O,
   output wire DISCHARGE_SWITCH_DRIVE_O,
   output wire PRECHARGE_SWITCH_DRIVE_O,
   output wire [NCELL-1:0] BALANCE_SWITCH_OUTPUTS_O,
   output wire PACK_SHUTDOWN_OUTPUT_O,
   output wire CHARGE_COMPLETE_N_O,
   output wire LOAD_ATTACHED_FLAG_O,
   output wire CHARGER_ATTACHED_FLAG_O
);
   reg lockout_high_cell_flag_ff, timed_high_cell_flag_ff, charge_complete_flag_ff;
   reg broken_sense_lead_flag_ff, cell_imbalance_flag_ff, discharge_short_flag_ff;
   reg discharge_overcurrent_flag_ff, charge_overcurrent_flag_ff, die_overheat_flag_ff;
   reg load_attached_flag_ff, charger_attached_flag_ff;
   reg charge_fet_ff, discharge_fet_ff;
   reg [1:0] load_clear_cnt_ff, charger_clear_cnt_ff;
   wire ext_fet = EXTERNAL_POWER_SWITCH_CONTROL_I;

   // comparisons against the scan results
   wire lockout_en = HIGH_CELL_LOCKOUT_I != `LEVEL_DISABLE_CODE; // RULE_03
   wire lockout_set = lockout_en && SCAN_DONE_I && (CELL_MAX_I > HIGH_CELL_LOCKOUT_I); // RULE_01
   wire below_recovery = CELL_MAX_I < HIGH_CELL_RECOVERY_LEVEL_I;
   wire ov_en = HIGH_CELL_LEVEL_I != `LEVEL_DISABLE_CODE; // RULE_07
   wire ov_above = ov_en && (CELL_MAX_I > HIGH_CELL_LEVEL_I);
   wire [11:0] eoc_clear_level = (CHARGE_COMPLETE_LEVEL_I > `EOC_HYST_CODE) ?
      CHARGE_COMPLETE_LEVEL_I - `EOC_HYST_CODE : 12'h000;
   wire [11:0] spread = CELL_MAX_I - CELL_MIN_I;
   wire diff_en = MAX_BALANCE_DIFFERENTIAL_I != `LEVEL_DISABLE_CODE; // RULE_15
   wire imbalance_now = diff_en && (spread > MAX_BALANCE_DIFFERENTIAL_I);
   // open lead test is triggered by an imbalance, so it dies with the spread check
   wire lead_test_en = diff_en && !BROKEN_LEAD_TEST_DISABLE_I; // RULE_15

   // qualification timers
   wire ov_done, ovr_done, dsc_done, doc_done, coc_done;
   fault_delay_timer #(.CW(TW)) u_ov_set (.CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I),
      .cond_i(ov_above && !timed_high_cell_flag_ff), .tick_i(DELAY_TICK_I),
      .limit_i(HIGH_CELL_DELAY_I), .done_o(ov_done));
   fault_delay_timer #(.CW(TW)) u_ov_clr (.CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I),
      .cond_i(below_recovery && timed_high_cell_flag_ff), .tick_i(DELAY_TICK_I),
      .limit_i(HIGH_CELL_DELAY_I), .done_o(ovr_done));
   fault_delay_timer #(.CW(TW)) u_dsc (.CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I),
      .cond_i(SHORT_OVER_I), .tick_i(DELAY_TICK_I),
      .limit_i(DISCHARGE_SHORT_DELAY_I), .done_o(dsc_done));
   fault_delay_timer #(.CW(TW)) u_doc (.CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I),
      .cond_i(DOC_OVER_I), .tick_i(DELAY_TICK_I),
      .limit_i(DOC_DELAY_I), .done_o(doc_done));
   fault_delay_timer #(.CW(TW)) u_coc (.CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I),
      .cond_i(COC_OVER_I), .tick_i(DELAY_TICK_I),
      .limit_i(COC_DELAY_I), .done_o(coc_done));

   // no-load scan counting for automatic recovery
   wire load_fault = discharge_short_flag_ff || discharge_overcurrent_flag_ff;
   wire load_scan_clear = LOAD_WATCH_SCAN_I && !LOAD_WATCH_PIN_LOAD_I;
   wire load_auto_clr = !EXTERNAL_LOAD_WATCH_CONTROL_I && load_scan_clear &&
      (load_clear_cnt_ff == `LOAD_CLEAR_SCANS - 2'h1); // RULE_18
   wire load_host_clr = EXTERNAL_LOAD_WATCH_CONTROL_I && LOAD_ERROR_CLEAR_I &&
      !load_attached_flag_ff; // RULE_19
   wire charger_scan_clear = CHARGER_WATCH_SCAN_I && !CHARGER_WATCH_PIN_CHARGER_I;
   wire chg_auto_clr = !EXTERNAL_CHARGER_WATCH_CONTROL_I && charger_scan_clear &&
      (charger_clear_cnt_ff == `LOAD_CLEAR_SCANS - 2'h1); // RULE_21
   wire chg_host_clr = EXTERNAL_CHARGER_WATCH_CONTROL_I && CHARGER_ERROR_CLEAR_I &&
      !charger_attached_flag_ff; // RULE_21
   wire dsc_set = dsc_done && !discharge_short_flag_ff;
   wire doc_set = doc_done && !discharge_overcurrent_flag_ff;
   wire coc_set = coc_done && !charge_overcurrent_flag_ff;
   wire lead_set = lead_test_en && BROKEN_LEAD_SCAN_DONE_I && BROKEN_LEAD_FOUND_I;

   // scan counters restart on a scan that still sees the other party
   always @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
         load_clear_cnt_ff <= 2'h0;
         charger_clear_cnt_ff <= 2'h0;
      end else begin
         if (!load_fault || (LOAD_WATCH_SCAN_I && LOAD_WATCH_PIN_LOAD_I) || load_auto_clr)
            load_clear_cnt_ff <= 2'h0;
         else if (load_scan_clear)
            load_clear_cnt_ff <= load_clear_cnt_ff + 2'h1;
         if (!charge_overcurrent_flag_ff || (CHARGER_WATCH_SCAN_I && CHARGER_WATCH_PIN_CHARGER_I)
               || chg_auto_clr)
            charger_clear_cnt_ff <= 2'h0;
         else if (charger_scan_clear)
            charger_clear_cnt_ff <= charger_clear_cnt_ff + 2'h1;
      end
   end

   // fault flags; a set always wins over a clear in the same cycle
   always @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
         lockout_high_cell_flag_ff <= 1'b0;
         timed_high_cell_flag_ff <= 1'b0;
         charge_complete_flag_ff <= 1'b0;
         broken_sense_lead_flag_ff <= 1'b0;
         cell_imbalance_flag_ff <= 1'b0;
         discharge_short_flag_ff <= 1'b0;
         discharge_overcurrent_flag_ff <= 1'b0;
         charge_overcurrent_flag_ff <= 1'b0;
         die_overheat_flag_ff <= 1'b0;
      end else begin
         if (lockout_set)
            lockout_high_cell_flag_ff <= 1'b1; // RULE_01
         else if (SCAN_DONE_I && below_recovery)
            lockout_high_cell_flag_ff <= 1'b0; // RULE_02
         if (ov_done)
            timed_high_cell_flag_ff <= 1'b1; // RULE_05
         else if (ovr_done || !ov_en)
            timed_high_cell_flag_ff <= 1'b0; // RULE_06
         if (SCAN_DONE_I && CELL_MAX_I > CHARGE_COMPLETE_LEVEL_I)
            charge_complete_flag_ff <= 1'b1; // RULE_08
         else if (SCAN_DONE_I && CELL_MAX_I < eoc_clear_level)
            charge_complete_flag_ff <= 1'b0; // RULE_09
         if (lead_set)
            broken_sense_lead_flag_ff <= 1'b1; // RULE_11
         else if (!lead_test_en || BROKEN_LEAD_SCAN_DONE_I)
            broken_sense_lead_flag_ff <= 1'b0; // RULE_12
         if (SCAN_DONE_I)
            cell_imbalance_flag_ff <= imbalance_now; // RULE_13 RULE_14
         else if (!diff_en)
            cell_imbalance_flag_ff <= 1'b0;
         if (dsc_set)
            discharge_short_flag_ff <= 1'b1; // RULE_16
         else if (load_auto_clr || load_host_clr)
            discharge_short_flag_ff <= 1'b0; // RULE_18
         if (doc_set)
            discharge_overcurrent_flag_ff <= 1'b1; // RULE_17
         else if (load_auto_clr || load_host_clr)
            discharge_overcurrent_flag_ff <= 1'b0; // RULE_18
         if (coc_set)
            charge_overcurrent_flag_ff <= 1'b1; // RULE_20
         else if (chg_auto_clr || chg_host_clr)
            charge_overcurrent_flag_ff <= 1'b0; // RULE_21
         if (DIE_ABOVE_LIMIT_I)
            die_overheat_flag_ff <= 1'b1; // RULE_22
         else if (DIE_BELOW_RECOVERY_I)
            die_overheat_flag_ff <= 1'b0; // RULE_22
      end
   end

   // attached flags follow the watch pins while their fault stands
   always @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
         load_attached_flag_ff <= 1'b0;
         charger_attached_flag_ff <= 1'b0;
      end else begin
         if (dsc_set || doc_set)
            load_attached_flag_ff <= 1'b1; // RULE_16 RULE_17
         else if (LOAD_WATCH_SCAN_I)
            load_attached_flag_ff <= load_fault && LOAD_WATCH_PIN_LOAD_I;
         if (coc_set)
            charger_attached_flag_ff <= 1'b1; // RULE_20
         else if (CHARGER_WATCH_SCAN_I)
            charger_attached_flag_ff <= charge_overcurrent_flag_ff && CHARGER_WATCH_PIN_CHARGER_I;
      end
   end

   // power switch blocking terms
   wire gated_fault = broken_sense_lead_flag_ff || cell_imbalance_flag_ff ||
      discharge_overcurrent_flag_ff || charge_overcurrent_flag_ff; // RULE_11 RULE_13
   wire hard_off = discharge_short_flag_ff || die_overheat_flag_ff; // RULE_16 RULE_22
   wire power_off = hard_off || (!ext_fet && gated_fault); // RULE_17 RULE_20
   // lockout holds the charge switch unless the controller owns the scan
   wire lockout_block = lockout_high_cell_flag_ff && !EXTERNAL_SCAN_OVERRIDE_I; // RULE_03
   wire charge_block = lockout_block || (!ext_fet && timed_high_cell_flag_ff); // RULE_05

   // automatic switch state; under external control the host bits are used instead
   always @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
         charge_fet_ff <= 1'b0;
         discharge_fet_ff <= 1'b0;
      end else if (ext_fet) begin
         charge_fet_ff <= HOST_CHARGE_SWITCH_I; // RULE_19
         discharge_fet_ff <= HOST_DISCHARGE_SWITCH_I;
      end else begin
         // re-enabled as soon as no fault remains
         charge_fet_ff <= !power_off && !charge_block; // RULE_06 RULE_18 RULE_21
         discharge_fet_ff <= !power_off; // RULE_18
      end
   end

   // precharge replaces charge when selected in automatic mode; under external control the host bit drives it; charge-complete never blocks it
   wire charge_on = charge_fet_ff && !power_off && !charge_block; // RULE_01 RULE_08
   assign CHARGE_SWITCH_DRIVE_O = charge_on && !PRECHARGE_SELECT_I;
   assign PRECHARGE_SWITCH_DRIVE_O = ext_fet ?
      (HOST_PRECHARGE_SWITCH_I && !power_off && !charge_block) :
      (charge_on && PRECHARGE_SELECT_I);
   assign DISCHARGE_SWITCH_DRIVE_O = discharge_fet_ff && !power_off;

   // balancing: allowed at charge complete when the option is set, stopped by power-off faults and lockout
   wire balance_stop = power_off || lockout_high_cell_flag_ff; // RULE_01 RULE_22
   wire eoc_balance = BALANCE_AT_CHARGE_COMPLETE_I && charge_complete_flag_ff; // RULE_10
   genvar gi;
   generate
      for (gi = 0; gi < NCELL; gi = gi + 1) begin : g_bal
         assign BALANCE_SWITCH_OUTPUTS_O[gi] = !balance_stop && BALANCE_REQUEST_I[gi] &&
            (CHARGING_I || eoc_balance); // RULE_10
      end
   endgenerate

   // shutdown output
   assign PACK_SHUTDOWN_OUTPUT_O = lockout_high_cell_flag_ff || // RULE_01
      (BROKEN_LEAD_FORCES_SHUTDOWN_I && broken_sense_lead_flag_ff) || // RULE_12
      (IMBALANCE_FORCES_SHUTDOWN_I && cell_imbalance_flag_ff); // RULE_14
   assign CHARGE_COMPLETE_N_O = !charge_complete_flag_ff; // RULE_08
   assign LOAD_ATTACHED_FLAG_O = load_attached_flag_ff;
   assign CHARGER_ATTACHED_FLAG_O = charger_attached_flag_ff;

   // status read; other bits of the first register belong elsewhere and read zero
   always @* begin
      REG_RDATA_O = 8'h00;
      case (REG_ADDR_I)
         `PRIMARY_FAULT_STATUS_ADDR: begin
            REG_RDATA_O[`BIT_HIGH_CELL_FLAG] = timed_high_cell_flag_ff;
            REG_RDATA_O[`BIT_LOCKOUT_FLAG] = lockout_high_cell_flag_ff;
         end
         `SECONDARY_FAULT_STATUS_ADDR: begin
            REG_RDATA_O[`BIT_DIE_OVERHEAT] = die_overheat_flag_ff;
            REG_RDATA_O[`BIT_CHARGE_OC] = charge_overcurrent_flag_ff;
            REG_RDATA_O[`BIT_DISCHARGE_OC] = discharge_overcurrent_flag_ff;
            REG_RDATA_O[`BIT_SHORT] = discharge_short_flag_ff;
            REG_RDATA_O[`BIT_IMBALANCE] = cell_imbalance_flag_ff;
            REG_RDATA_O[`BIT_BROKEN_LEAD] = broken_sense_lead_flag_ff;
            REG_RDATA_O[`BIT_CHARGE_COMPLETE] = charge_complete_flag_ff;
         end
         default: REG_RDATA_O = 8'h00;
      endcase
   end
endmodule // pack_fault_status

// [tb/watch_host_model.sv]
// controller model that recovers a watch fault while it owns the watch circuit
module watch_host_model (
   input wire clk_i,
   input wire rst_i,
   input wire go_i,
   input wire attached_i,
   output reg scan_o,
   output reg clear_o,
   output reg done_o
);
   timeunit 1ns;
   timeprecision 1ps;
   reg [2:0] cnt_ff;
   reg armed_ff;
   // pulse the watch every 8 cycles, clear once only after a scan saw nothing attached
   always @(posedge clk_i) begin
      if (rst_i || !go_i) begin
         cnt_ff <= 3'h0;
         armed_ff <= 1'b0;
         scan_o <= 1'b0;
         clear_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         cnt_ff <= cnt_ff + 3'h1;
         scan_o <= (cnt_ff == 3'h7) && !done_o;
         clear_o <= 1'b0;
         if (scan_o)
            armed_ff <= 1'b1;
         // a stale attached reading before any scan must not clear the error
         if (armed_ff && !scan_o && !attached_i && !done_o) begin
            clear_o <= 1'b1;
            done_o <= 1'b1;
         end
      end
   end
endmodule // watch_host_model

// [tb/pack_fault_checker.sv]
// assertion checker bound to the pack fault status logic
module pack_fault_checker #(parameter NCELL = 8) (
   input wire CORE_CLK_I, SYS_RST_I, SCAN_DONE_I, BROKEN_LEAD_FORCES_SHUTDOWN_I,
   input wire BROKEN_LEAD_TEST_DISABLE_I, IMBALANCE_FORCES_SHUTDOWN_I, BROKEN_LEAD_SCAN_DONE_I,
   input wire BROKEN_LEAD_FOUND_I, EXTERNAL_POWER_SWITCH_CONTROL_I, EXTERNAL_SCAN_OVERRIDE_I,
   input wire CHARGE_SWITCH_DRIVE_O, DISCHARGE_SWITCH_DRIVE_O, PRECHARGE_SWITCH_DRIVE_O,
   input wire PACK_SHUTDOWN_OUTPUT_O, CHARGE_COMPLETE_N_O,
   input wire [11:0] CELL_MAX_I, CELL_MIN_I, HIGH_CELL_LOCKOUT_I, HIGH_CELL_LEVEL_I,
   input wire [11:0] CHARGE_COMPLETE_LEVEL_I, MAX_BALANCE_DIFFERENTIAL_I,
   input wire [7:0] REG_ADDR_I, REG_RDATA_O, input wire [NCELL-1:0] BALANCE_SWITCH_OUTPUTS_O
);
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (SYS_RST_I);
   // helpers
   wire bal_off = (BALANCE_SWITCH_OUTPUTS_O == {NCELL{1'b0}});
   wire all_off = bal_off && !CHARGE_SWITCH_DRIVE_O && !DISCHARGE_SWITCH_DRIVE_O
      && !PRECHARGE_SWITCH_DRIVE_O;
   wire [12:0] spread = {1'b0, CELL_MAX_I} - {1'b0, CELL_MIN_I};
   wire s0 = (REG_ADDR_I == 8'h80);
   wire s1 = (REG_ADDR_I == 8'h81);
   lockout_set_a: assert property (SCAN_DONE_I && CELL_MAX_I > HIGH_CELL_LOCKOUT_I
      && HIGH_CELL_LOCKOUT_I != 12'hFFF && !EXTERNAL_SCAN_OVERRIDE_I
      |=> PACK_SHUTDOWN_OUTPUT_O && !CHARGE_SWITCH_DRIVE_O && bal_off)
      else $error("lockout not applied");
   lockout_hold_a: assert property (s0 && REG_RDATA_O[1] |-> PACK_SHUTDOWN_OUTPUT_O
      && (EXTERNAL_SCAN_OVERRIDE_I || !CHARGE_SWITCH_DRIVE_O) && bal_off)
      else $error("lockout actions missing");
   timed_off_a: assert property (s0 && REG_RDATA_O[0] && !EXTERNAL_POWER_SWITCH_CONTROL_I
      |-> !CHARGE_SWITCH_DRIVE_O) else $error("charge on with timed flag");
   timed_dis_a: assert property ((HIGH_CELL_LEVEL_I == 12'hFFF)[*3] ##0 (s0 && !REG_RDATA_O[0])
      |=> !(s0 && REG_RDATA_O[0])) else $error("timed flag while disabled");
   eoc_set_a: assert property (SCAN_DONE_I && CELL_MAX_I > CHARGE_COMPLETE_LEVEL_I
      |=> !CHARGE_COMPLETE_N_O) else $error("charge complete pin high");
   eoc_hold_a: assert property (!CHARGE_COMPLETE_N_O && !(SCAN_DONE_I
      && {1'b0, CELL_MAX_I} + 13'h0064 < {1'b0, CHARGE_COMPLETE_LEVEL_I})
      |=> !CHARGE_COMPLETE_N_O) else $error("early charge complete release");
   lead_psd_a: assert property (BROKEN_LEAD_SCAN_DONE_I && BROKEN_LEAD_FOUND_I
      && !BROKEN_LEAD_TEST_DISABLE_I && BROKEN_LEAD_FORCES_SHUTDOWN_I
      && MAX_BALANCE_DIFFERENTIAL_I != 12'hFFF |=> PACK_SHUTDOWN_OUTPUT_O)
      else $error("open lead without shutdown");
   imb_psd_a: assert property (SCAN_DONE_I && MAX_BALANCE_DIFFERENTIAL_I != 12'hFFF
      && spread > {1'b0, MAX_BALANCE_DIFFERENTIAL_I} && IMBALANCE_FORCES_SHUTDOWN_I
      |=> PACK_SHUTDOWN_OUTPUT_O) else $error("imbalance without shutdown");
   short_off_a: assert property (s1 && REG_RDATA_O[3] |-> all_off)
      else $error("switch on in short");
   die_off_a: assert property (s1 && REG_RDATA_O[0] |-> all_off)
      else $error("switch on in overheat");
   cover property (s1 && REG_RDATA_O[3]);
   cover property (s1 && REG_RDATA_O[2]);
   cover property (!CHARGE_COMPLETE_N_O && !bal_off);
endmodule // pack_fault_checker
// every checker port has the same name as a port of the bound module
bind pack_fault_status pack_fault_checker #(.NCELL(NCELL)) chk (.*);

// [tb/test_pack_fault_status.sv]
// self-checking bench for the pack fault status logic
module test_pack_fault_status;
   timeunit 1ns;
   timeprecision 1ps;
   reg clk = 1'b0, rst = 1'b1, sd = 1'b0, tk = 1'b0, beo = 1'b0, osd = 1'b0, odis = 1'b0;
   reg isd = 1'b0, lsd = 1'b0, lfd = 1'b0, sc = 1'b0, discharge_overcurrent_threshold = 1'b0, charge_overcurrent_threshold = 1'b0, die = 1'b0;
   reg dier = 1'b0, lws = 1'b0, lp = 1'b0, cws = 1'b0, cp = 1'b0, xp = 1'b0, xo = 1'b0;
   reg xl = 1'b0, xc = 1'b0, hs = 1'b1, pre = 1'b0, chg = 1'b0, lgo = 1'b0, cgo = 1'b0;
   reg [11:0] mx = 12'h000, mn = 12'h000, lock = 12'hE00, lvl = 12'hD00, rec = 12'hC00;
   reg [11:0] eoc = 12'hC80, dif = 12'h200;
   reg [15:0] dly = 16'h0002;
   reg [7:0] ra = 8'h00, rq = 8'hA5;
   wire [7:0] rdo, bo;
   wire c_o, d_o, p_o, pack_shutdown_output, eoc_n, lda, cha, l_scan, l_clr, l_done, c_scan, c_clr, c_done;
   integer err_total = 0, comparisons = 0;
   pack_fault_status #(.NCELL(8), .TW(16)) dut (.CORE_CLK_I(clk), .SYS_RST_I(rst),
      .SCAN_DONE_I(sd), .CELL_MAX_I(mx), .CELL_MIN_I(mn), .DELAY_TICK_I(tk),
      .HIGH_CELL_LOCKOUT_I(lock), .HIGH_CELL_LEVEL_I(lvl), .HIGH_CELL_RECOVERY_LEVEL_I(rec),
      .HIGH_CELL_DELAY_I(dly), .CHARGE_COMPLETE_LEVEL_I(eoc), .MAX_BALANCE_DIFFERENTIAL_I(dif),
      .BALANCE_AT_CHARGE_COMPLETE_I(beo), .BROKEN_LEAD_FORCES_SHUTDOWN_I(osd),
      .BROKEN_LEAD_TEST_DISABLE_I(odis), .IMBALANCE_FORCES_SHUTDOWN_I(isd),
      .BROKEN_LEAD_SCAN_DONE_I(lsd), .BROKEN_LEAD_FOUND_I(lfd), .SHORT_OVER_I(sc),
      .DISCHARGE_SHORT_DELAY_I(dly), .DOC_OVER_I(discharge_overcurrent_threshold), .DOC_DELAY_I(dly), .COC_OVER_I(charge_overcurrent_threshold),
      .COC_DELAY_I(dly), .DIE_ABOVE_LIMIT_I(die), .DIE_BELOW_RECOVERY_I(dier),
      .LOAD_WATCH_SCAN_I(lws | l_scan), .LOAD_WATCH_PIN_LOAD_I(lp),
      .CHARGER_WATCH_SCAN_I(cws | c_scan), .CHARGER_WATCH_PIN_CHARGER_I(cp),
      .EXTERNAL_POWER_SWITCH_CONTROL_I(xp), .EXTERNAL_SCAN_OVERRIDE_I(xo),
      .EXTERNAL_LOAD_WATCH_CONTROL_I(xl), .EXTERNAL_CHARGER_WATCH_CONTROL_I(xc),
      .LOAD_ERROR_CLEAR_I(l_clr), .CHARGER_ERROR_CLEAR_I(c_clr), .HOST_CHARGE_SWITCH_I(hs),
      .HOST_DISCHARGE_SWITCH_I(hs), .HOST_PRECHARGE_SWITCH_I(1'b0), .PRECHARGE_SELECT_I(pre),
      .BALANCE_REQUEST_I(rq), .CHARGING_I(chg), .REG_ADDR_I(ra), .REG_RDATA_O(rdo),
      .CHARGE_SWITCH_DRIVE_O(c_o), .DISCHARGE_SWITCH_DRIVE_O(d_o),
      .PRECHARGE_SWITCH_DRIVE_O(p_o), .BALANCE_SWITCH_OUTPUTS_O(bo),
      .PACK_SHUTDOWN_OUTPUT_O(pack_shutdown_output), .CHARGE_COMPLETE_N_O(eoc_n),
      .LOAD_ATTACHED_FLAG_O(lda), .CHARGER_ATTACHED_FLAG_O(cha));
   watch_host_model lhost (.clk_i(clk), .rst_i(rst), .go_i(lgo), .attached_i(lda),
      .scan_o(l_scan), .clear_o(l_clr), .done_o(l_done));
   watch_host_model chost (.clk_i(clk), .rst_i(rst), .go_i(cgo), .attached_i(cha),
      .scan_o(c_scan), .clear_o(c_clr), .done_o(c_done));
   // 20 MHz core clock
   always #25 clk = ~clk;
   task chk(input [7:0] e, input [7:0] g);
      comparisons = comparisons + 1;
      if (g !== e) begin
         err_total = err_total + 1;
         $display("BAD t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   // status read is combinational
   task rd(input [7:0] a, input [7:0] e);
      @(negedge clk);
      ra = a;
      #1 chk(e, rdo);
   endtask
   // order: shutdown, charge complete (low active), charge, discharge, precharge
   task po(input [4:0] e);
      chk({3'h0, e}, {3'h0, pack_shutdown_output, eoc_n, c_o, d_o, p_o});
   endtask
   task scan(input [11:0] hi, input [11:0] lo);
      @(negedge clk);
      sd = 1'b1;
      mx = hi;
      mn = lo;
      @(negedge clk);
      sd = 1'b0;
   endtask
   task ticks(input integer n);
      @(negedge clk);
      tk = 1'b1;
      repeat (n) @(negedge clk);
      tk = 1'b0;
   endtask
   task lscan(input f);
      @(negedge clk);
      lsd = 1'b1;
      lfd = f;
      @(negedge clk);
      lsd = 1'b0;
   endtask
   // w selects the charger watch, v is what the pin sees
   task wscan(input w, input v);
      @(negedge clk);
      lws = !w;
      cws = w;
      lp = v;
      cp = v;
      @(negedge clk);
      lws = 1'b0;
      cws = 1'b0;
   endtask
   task fin(input [63:0] n);
      $display("test %0s ended", n);
   endtask
   task test_done;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // watchdog
   initial begin
      repeat (4000) @(posedge clk);
      err_total = err_total + 1;
      test_done;
   end
   initial begin
      repeat (6) @(negedge clk);
      rst = 1'b0;
      rd(8'h80, 8'h00); rd(8'h81, 8'h00); rd(8'h82, 8'h00); po(5'b01110); fin("reset");
      scan(12'hE10, 12'hE00); rd(8'h80, 8'h02); po(5'b10010); chk(8'h00, bo);
      scan(12'hBFF, 12'hBF0); rd(8'h80, 8'h00); rd(8'h81, 8'h00);
      lock = 12'hFFF;
      scan(12'hE10, 12'hE00); rd(8'h80, 8'h00); po(5'b00110);
      scan(12'hC20, 12'hC10); rd(8'h81, 8'h80);
      scan(12'hC10, 12'hC00); rd(8'h81, 8'h00);
      lock = 12'hE00;
      xo = 1'b1;
      scan(12'hE10, 12'hE00); rd(8'h80, 8'h02);
      xo = 1'b0;
      scan(12'hB00, 12'hAF0); fin("lockout");
      scan(12'hD80, 12'hD70); ticks(4); rd(8'h80, 8'h01); po(5'b00010);
      scan(12'hB00, 12'hAF0); ticks(2); rd(8'h80, 8'h01);
      ticks(2); rd(8'h80, 8'h00); po(5'b01110);
      lvl = 12'hFFF;
      scan(12'hD80, 12'hD70); ticks(4); rd(8'h80, 8'h00);
      scan(12'hB00, 12'hAF0);
      lvl = 12'hD00;
      fin("timed");
      isd = 1'b1;
      osd = 1'b1;
      scan(12'hB00, 12'h800); rd(8'h81, 8'h10); po(5'b11000); chk(8'h00, bo);
      lscan(1'b1); rd(8'h81, 8'h30); lscan(1'b0); rd(8'h81, 8'h10);
      scan(12'hB00, 12'hA00); rd(8'h81, 8'h00); po(5'b01110);
      dif = 12'hFFF;
      scan(12'hB00, 12'h100); lscan(1'b1); rd(8'h81, 8'h00);
      dif = 12'h200;
      odis = 1'b1;
      lscan(1'b1); rd(8'h81, 8'h00);
      odis = 1'b0;
      fin("spread");
      xp = 1'b1;
      sc = 1'b1;
      ticks(4);
      sc = 1'b0;
      rd(8'h81, 8'h08); po(5'b01000);
      wscan(1'b0, 1'b1); chk(8'h01, {7'h00, lda});
      lp = 1'b0;
      xl = 1'b1;
      lgo = 1'b1;
      repeat (200) if (!l_done) @(negedge clk);
      lgo = 1'b0;
      rd(8'h81, 8'h00); po(5'b01110);
      xl = 1'b0;
      xp = 1'b0;
      discharge_overcurrent_threshold = 1'b1;
      ticks(4);
      discharge_overcurrent_threshold = 1'b0;
      rd(8'h81, 8'h04); po(5'b01000);
      wscan(1'b0, 1'b1); wscan(1'b0, 1'b0); rd(8'h81, 8'h04);
      wscan(1'b0, 1'b1); wscan(1'b0, 1'b0); rd(8'h81, 8'h04);
      wscan(1'b0, 1'b0); rd(8'h81, 8'h00); po(5'b01110); fin("load");
      charge_overcurrent_threshold = 1'b1;
      ticks(4);
      charge_overcurrent_threshold = 1'b0;
      rd(8'h81, 8'h02); po(5'b01000);
      wscan(1'b1, 1'b1); chk(8'h01, {7'h00, cha});
      cp = 1'b0;
      xc = 1'b1;
      cgo = 1'b1;
      repeat (200) if (!c_done) @(negedge clk);
      cgo = 1'b0;
      rd(8'h81, 8'h00); @(negedge clk); po(5'b01110); fin("charger");
      xc = 1'b0;
      die = 1'b1;
      rd(8'h81, 8'h01); po(5'b01000); chk(8'h00, bo);
      die = 1'b0;
      rd(8'h81, 8'h01); po(5'b01000);
      dier = 1'b1;
      rd(8'h81, 8'h00); @(negedge clk); po(5'b01110); fin("die");
      beo = 1'b1;
      scan(12'hCA0, 12'hC90); rd(8'h81, 8'h80); chk(8'hA5, bo); fin("balance");
      test_done;
   end
endmodule // test_pack_fault_status
